// ===== logic/sbc_regs.svh
// Offsets, field positions, reset values and counts of the standby controller
// Included by the design modules, the checker and the bench
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

`define SBC_STAB_STATUS_ADDR  16'hffa3
`define SBC_TIME_SELECT_ADDR  16'hffaa
`define SBC_STAB_STATUS_RST   8'h00
`define SBC_TIME_SELECT_RST   3'h5
`define SBC_SEL_MIN           3'h1
`define SBC_SEL_MAX           3'h5
`define SBC_RING_HOLD_CYC     5'h11
`define SBC_CNT_W             17
`define SBC_EXP_2P11          5'h0b
`define SBC_EXP_2P13          5'h0d
`define SBC_EXP_2P14          5'h0e
`define SBC_EXP_2P15          5'h0f
`define SBC_EXP_2P16          5'h10

`endif

// ===== logic/sbc_pkg.sv
// Types of the standby controller
// Constants come from sbc_regs.svh
package sbc_pkg;

  typedef enum logic [1:0] {
    SBC_SRC_MAIN,
    SBC_SRC_RING,
    SBC_SRC_SUB
  } sbc_src_e;

  typedef enum logic [2:0] {
    SBC_RUN,
    SBC_HALT,
    SBC_STOP,
    SBC_OSC_START,
    SBC_STAB_WAIT,
    SBC_RING_HOLD
  } sbc_state_e;

  // Register port toward the CPU
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sbc_bus_s;

  // Clock gating and oscillator controls
  typedef struct packed {
    logic cpu_clk_en;
    logic main_osc_en;
    logic internal_ring_oscillator_en;
    logic sub_osc_en;
  } sbc_clk_s;

endpackage : sbc_pkg

// ===== logic/sbc_stab_counter.sv
// Main oscillator stabilization counter with thermometer status
// Assumes main_osc_tick pulses once per main oscillator period, on ref_clk
`timescale 1ns/10ps
`include "sbc_regs.svh"
module sbc_stab_counter
  import sbc_pkg::*;
#(
  parameter int CNT_W = `SBC_CNT_W
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Control
  input  wire logic       clear,
  input  wire logic       run,
  input  wire logic       main_osc_tick,
  input  wire logic [2:0] sel,
  input  wire logic       limit_en,
  // Status
  output logic [4:0]      status,
  output logic            sel_done
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [4:0]       next_status;
  logic [4:0]       reached;
  logic [4:0]       allowed;
  logic [4:0]       expo [5];

  assign expo[0] = `SBC_EXP_2P16;
  assign expo[1] = `SBC_EXP_2P15;
  assign expo[2] = `SBC_EXP_2P14;
  assign expo[3] = `SBC_EXP_2P13;
  assign expo[4] = `SBC_EXP_2P11;

  // Status bit 4 is 2^11, bit 0 is 2^16; sel 1..5 allows 1..5 bits from the top
  for (genvar i = 0; i < 5; i++) begin : g_bit
    assign reached[i] = cnt[expo[i]];
    assign allowed[i] = !limit_en || (sel > 3'(4 - i));
  end

  // Lowest allowed bit is the longest wait; it ends the count
  assign sel_done = |(status & allowed & ~(allowed << 1)) || (sel == 3'h0);

  always_comb begin
    next_cnt    = cnt;
    next_status = status;
    if (clear) begin
      next_cnt    = '0;
      next_status = '0;
    end else if (run && main_osc_tick) begin
      if (!cnt[CNT_W-1] && !(limit_en && sel_done)) begin
        next_cnt = cnt + CNT_W'(1);
      end
      next_status = status | (reached & allowed);
    end else if (run) begin
      next_status = status | (reached & allowed);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt    <= '0;
      status <= '0;
    end else begin
      cnt    <= next_cnt;
      status <= next_status;
    end
  end

endmodule : sbc_stab_counter

// ===== logic/sbc_standby.sv
// Standby controller: halt and stop modes, oscillator control, stabilization status
// Assumes CPU decode gives halt/stop pulses and register port on ref_clk;
// oscillator-started and interrupt levels arrive from outside and are synchronised.
// Function
// - Halt gates the CPU clock; running oscillators keep running.
// - Stop turns off the main crystal oscillator.
// - An interrupt request releases stop mode.
// - Halt and stop keep registers, memory and port state unchanged.
// - Stop while on the ring oscillator keeps the ring running.
// - After stop on ring clock, CPU held 17 ring periods.
// - Status cleared on reset, stop, crystal-stop write or main-clock bit write.
// - Status bits set from bit 4 down at 2^11..2^16 periods and stay set.
// - After stop release, counting ends at the selected wait time.
// - The stop-release wait begins only after oscillation has started.
// - After stop, the CPU clock source before stop is used again.
// - After halt, the CPU clock source before halt is used again.
// - Ring stop bit works only when ring is software-stoppable.
// - Time select resets to 5; codes 1..5 pick 2^11..2^16 waits.
// - The selected wait applies only with the main crystal as CPU clock.
`timescale 1ns/10ps
`include "sbc_regs.svh"
module sbc_standby
  import sbc_pkg::*;
#(
  parameter bit RING_STOPPABLE = 1'b1
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // CPU instruction events
  input  wire logic       halt_exec,
  input  wire logic       stop_exec,
  input  wire sbc_src_e   cpu_src,
  // Register port
  input  wire sbc_bus_s   bus,
  output logic [7:0]      rdata,
  // Clock control writes from the clock generator
  input  wire logic       crystal_osc_stop_wr,
  input  wire logic       main_clock_ctrl_bit_wr,
  input  wire logic       internal_ring_oscillator_stop,
  input  wire logic       sub_osc_used,
  // Outside events
  input  wire logic       irq_pending,
  input  wire logic       main_osc_started,
  input  wire logic       main_osc_tick,
  input  wire logic       internal_ring_oscillator_tick,
  // Clock outputs
  output sbc_clk_s        clk_ctrl,
  output sbc_src_e        resume_src,
  output logic            standby
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] irq_sync;
  logic [1:0] start_sync;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_sync   <= '0;
      start_sync <= '0;
    end else begin
      irq_sync   <= {irq_sync[0], irq_pending};
      start_sync <= {start_sync[0], main_osc_started};
    end
  end
  wire irq_s   = irq_sync[1];
  wire osc_up  = start_sync[1];

  // ****************************************
  // Time select register
  // ****************************************
  logic [2:0] time_sel;
  logic [2:0] next_time_sel;
  wire sel_wr = bus.wr && (bus.addr == `SBC_TIME_SELECT_ADDR);

  always_comb begin
    next_time_sel = time_sel;
    if (sel_wr) begin
      next_time_sel = bus.wdata[2:0];
    end
  end

  // ****************************************
  // Standby state machine
  // ****************************************
  sbc_state_e state;
  sbc_state_e next_state;
  sbc_src_e   saved_src;
  sbc_src_e   next_saved_src;
  logic [4:0] hold_cnt;
  logic [4:0] next_hold_cnt;
  logic       main_on;
  logic       next_main_on;
  logic       ring_on;
  logic       next_ring_on;
  logic       sel_done;
  logic [4:0] stat;

  always_comb begin
    next_state     = state;
    next_saved_src = saved_src;
    next_hold_cnt  = hold_cnt;
    next_main_on   = main_on;
    next_ring_on   = ring_on;
    if (crystal_osc_stop_wr) begin
      next_main_on = 1'b0;
    end
    if (RING_STOPPABLE && state == SBC_RUN) begin
      next_ring_on = !internal_ring_oscillator_stop || cpu_src == SBC_SRC_RING;
    end
    case (state)
      SBC_RUN: begin
        if (stop_exec && cpu_src != SBC_SRC_SUB) begin
          next_state     = SBC_STOP;
          next_saved_src = cpu_src;
          next_main_on   = 1'b0;
          next_ring_on   = ring_on || cpu_src == SBC_SRC_RING;
        end else if (halt_exec) begin
          next_state     = SBC_HALT;
          next_saved_src = cpu_src;
        end
      end
      SBC_HALT: begin
        if (irq_s) begin
          next_state = SBC_RUN;
        end
      end
      SBC_STOP: begin
        if (irq_s) begin
          next_state   = SBC_OSC_START;
          next_main_on = 1'b1;
        end
      end
      SBC_OSC_START: begin
        if (osc_up) begin
          next_hold_cnt = '0;
          next_state = (saved_src == SBC_SRC_MAIN) ? SBC_STAB_WAIT : SBC_RING_HOLD;
        end
      end
      SBC_STAB_WAIT: begin
        if (sel_done) begin
          next_state = SBC_RUN;
        end
      end
      SBC_RING_HOLD: begin
        if (internal_ring_oscillator_tick) begin
          next_hold_cnt = hold_cnt + 5'h01;
          if (hold_cnt == `SBC_RING_HOLD_CYC - 5'h01) begin
            next_state = SBC_RUN;
          end
        end
      end
      default: next_state = SBC_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state     <= SBC_RUN;
      saved_src <= SBC_SRC_RING;
      hold_cnt  <= '0;
      main_on   <= 1'b0;
      ring_on   <= 1'b1;
      time_sel  <= `SBC_TIME_SELECT_RST;
    end else begin
      state     <= next_state;
      saved_src <= next_saved_src;
      hold_cnt  <= next_hold_cnt;
      main_on   <= next_main_on;
      ring_on   <= next_ring_on;
      time_sel  <= next_time_sel;
    end
  end

  // ****************************************
  // Stabilization counter
  // ****************************************
  wire stab_clear = stop_exec && state == SBC_RUN || crystal_osc_stop_wr
                    || main_clock_ctrl_bit_wr;
  wire stab_run   = osc_up && state != SBC_STOP && state != SBC_OSC_START;

  sbc_stab_counter #(
    .CNT_W (`SBC_CNT_W)
  ) u_stab (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .clear         (stab_clear),
    .run           (stab_run),
    .main_osc_tick (main_osc_tick),
    .sel           (time_sel),
    .limit_en      (saved_src != SBC_SRC_SUB),
    .status        (stat),
    .sel_done      (sel_done)
  );

  // ****************************************
  // Read data and clock outputs
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata <= '0;
    end else if (bus.rd && bus.addr == `SBC_STAB_STATUS_ADDR) begin
      rdata <= {3'h0, stat};
    end else if (bus.rd && bus.addr == `SBC_TIME_SELECT_ADDR) begin
      rdata <= {5'h00, time_sel};
    end else begin
      rdata <= '0;
    end
  end

  // CPU clock enable is on only in SBC_RUN; oscillator enables follow main_on, ring_on and sub_osc_used
  always_comb begin
    clk_ctrl.cpu_clk_en  = (state == SBC_RUN);
    clk_ctrl.main_osc_en = main_on;
    clk_ctrl.internal_ring_oscillator_en = ring_on;
    clk_ctrl.sub_osc_en  = sub_osc_used;
  end
  assign resume_src = saved_src;
  assign standby    = (state != SBC_RUN);

endmodule : sbc_standby

// ===== dv/sbc_standby_props.sv
// Port checker of the standby controller
// Bound to sbc_standby; one clock, srst synchronous
`timescale 1ns/10ps
`include "sbc_regs.svh"
module sbc_standby_props
  import sbc_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // Watched inputs
  input wire logic       halt_exec,
  input wire logic       stop_exec,
  input wire sbc_src_e   cpu_src,
  input wire sbc_bus_s   bus,
  input wire logic       crystal_osc_stop_wr,
  input wire logic       main_clock_ctrl_bit_wr,
  input wire logic       irq_pending,
  input wire logic       main_osc_started,
  // Watched outputs
  input wire logic [7:0] rdata,
  input wire sbc_clk_s   clk_ctrl,
  input wire sbc_src_e   resume_src,
  input wire logic       standby
);
  // ****
  // Halt tracking and properties
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic in_halt;
  always_ff @(posedge ref_clk) begin
    in_halt <= srst ? 1'b0
             : (halt_exec && !standby && !(stop_exec && cpu_src != SBC_SRC_SUB)) ? 1'b1
             : (standby && in_halt);
  end
  halt_gate_a: assert property (halt_exec && !standby |=> !clk_ctrl.cpu_clk_en && standby
    && clk_ctrl.internal_ring_oscillator_en == $past(clk_ctrl.internal_ring_oscillator_en)) else $error("halt gating wrong");
  stop_main_a: assert property (stop_exec && !standby && cpu_src != SBC_SRC_SUB
    |=> !clk_ctrl.main_osc_en && standby) else $error("stop left main osc on");
  stop_ring_a: assert property (stop_exec && !standby && cpu_src == SBC_SRC_RING
    |=> clk_ctrl.internal_ring_oscillator_en) else $error("stop halted internal_ring_oscillator");
  osc_wait_a: assert property (standby && !in_halt && !main_osc_started && !clk_ctrl.cpu_clk_en
    |=> !clk_ctrl.cpu_clk_en) else $error("resumed before osc start");
  stat_therm_a: assert property (bus.rd && bus.addr == `SBC_STAB_STATUS_ADDR
    |=> rdata inside {8'h00, 8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f}) else $error("status order");
  stat_clear_a: assert property ((crystal_osc_stop_wr || main_clock_ctrl_bit_wr) ##1
    (bus.rd && bus.addr == `SBC_STAB_STATUS_ADDR) |=> rdata == 8'h00) else $error("no clear");
  resume_src_a: assert property ($fell(standby) |-> resume_src == cpu_src)
    else $error("resume source wrong");
  halt_exit_a: assert property (in_halt && $rose(irq_pending) |-> ##[1:4] !standby)
    else $error("halt exit late");
  cover property (in_halt ##1 !standby);
  cover property (stop_exec && cpu_src == SBC_SRC_MAIN);
  cover property (stop_exec && cpu_src == SBC_SRC_RING);
endmodule : sbc_standby_props

bind sbc_standby sbc_standby_props u_props (.ref_clk(ref_clk), .srst(srst),
  .halt_exec(halt_exec), .stop_exec(stop_exec), .cpu_src(cpu_src), .bus(bus),
  .crystal_osc_stop_wr(crystal_osc_stop_wr), .main_clock_ctrl_bit_wr(main_clock_ctrl_bit_wr),
  .irq_pending(irq_pending), .main_osc_started(main_osc_started), .rdata(rdata),
  .clk_ctrl(clk_ctrl), .resume_src(resume_src), .standby(standby));

// ===== dv/tb.sv
// Bench of the standby controller
// Assumes sbc_standby, sbc_pkg and a 100 MHz clock
`timescale 1ns/10ps
`include "sbc_regs.svh"
module tb;
  import sbc_pkg::*;
  logic ref_clk, srst, halt_exec, stop_exec, xstop_wr, mcc_wr, irq_pending, started, ring_tick;
  logic standby;
  logic ring_stop, sub_used;
  logic [7:0] rdata;
  sbc_src_e cpu_src, resume_src;
  sbc_bus_s bus;
  sbc_clk_s clk_ctrl;
  int err_total, num_checks;
  sbc_standby u_dut (.ref_clk(ref_clk), .srst(srst), .halt_exec(halt_exec),
    .stop_exec(stop_exec), .cpu_src(cpu_src), .bus(bus), .rdata(rdata),
    .crystal_osc_stop_wr(xstop_wr), .main_clock_ctrl_bit_wr(mcc_wr), .internal_ring_oscillator_stop(ring_stop),
    .sub_osc_used(sub_used), .irq_pending(irq_pending), .main_osc_started(started),
    .main_osc_tick(1'b1), .internal_ring_oscillator_tick(ring_tick), .clk_ctrl(clk_ctrl),
    .resume_src(resume_src), .standby(standby));
  // ****
  // Helpers
  // ****
  task automatic cy(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cy
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    bus = '{1'b0, 1'b1, a, 8'h00};
    cy(1);
    d = rdata;
    bus.rd = 1'b0;
    cy(1);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus = '{1'b1, 1'b0, a, d};
    cy(1);
    bus.wr = 1'b0;
    cy(1);
  endtask : wr
  task automatic pulse(ref logic s);
    s = 1'b1;
    cy(1);
    s = 1'b0;
  endtask : pulse
  task automatic await_run(input int lim, output int n);
    n = 0;
    while (clk_ctrl.cpu_clk_en !== 1'b1 && n < lim) begin
      cy(1);
      n++;
    end
  endtask : await_run
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    logic [7:0] d;
    rd(`SBC_STAB_STATUS_ADDR, d);
    chk("status_rst", 8'h00, d);
    rd(`SBC_TIME_SELECT_ADDR, d);
    chk("select_rst", 8'h05, d);
    rd(16'hff00, d);
    chk("unmapped", 8'h00, d);
  endtask : t_reset
  task automatic t_halt;
    int n;
    cpu_src = SBC_SRC_RING;
    pulse(halt_exec);
    chk("halt_gate", 8'h01,
        {7'h0, clk_ctrl.internal_ring_oscillator_en & clk_ctrl.sub_osc_en & ~clk_ctrl.cpu_clk_en});
    cy(20);
    irq_pending = 1'b1;
    await_run(6, n);
    chk("halt_exit", 8'h01, {7'h0, clk_ctrl.cpu_clk_en});
    chk("halt_src", 8'(SBC_SRC_RING), 8'(resume_src));
    irq_pending = 1'b0;
    cy(4);
  endtask : t_halt
  task automatic t_stop_main;
    int n;
    logic [7:0] d;
    wr(`SBC_TIME_SELECT_ADDR, 8'h01);
    cpu_src = SBC_SRC_MAIN;
    started = 1'b0;
    pulse(stop_exec);
    chk("main_off", 8'h00, {7'h0, clk_ctrl.main_osc_en});
    rd(`SBC_STAB_STATUS_ADDR, d);
    chk("stop_clear", 8'h00, d);
    irq_pending = 1'b1;
    cy(30);
    chk("main_on", 8'h01, {7'h0, clk_ctrl.main_osc_en});
    rd(`SBC_STAB_STATUS_ADDR, d);
    chk("no_count", 8'h00, d);
    started = 1'b1;
    await_run(2100, n);
    chk("wait_len", 8'h01, {7'h0, n >= 2048 && n < 2060});
    chk("stop_src", 8'(SBC_SRC_MAIN), 8'(resume_src));
    irq_pending = 1'b0;
    cy(6500);
    rd(`SBC_STAB_STATUS_ADDR, d);
    chk("sel_limit", 8'h10, d);
  endtask : t_stop_main
  task automatic t_stop_ring;
    int n;
    logic [7:0] d;
    wr(`SBC_TIME_SELECT_ADDR, 8'h02);
    cpu_src = SBC_SRC_RING;
    pulse(stop_exec);
    started = 1'b0;
    chk("ring_kept", 8'h01, {7'h0, clk_ctrl.internal_ring_oscillator_en});
    chk("ring_main_off", 8'h00, {7'h0, clk_ctrl.main_osc_en});
    irq_pending = 1'b1;
    cy(4);
    started = 1'b1;
    cy(4);
    for (int i = 0; i < 16; i++) begin
      pulse(ring_tick);
      cy(2);
    end
    chk("ring_hold", 8'h00, {7'h0, clk_ctrl.cpu_clk_en});
    pulse(ring_tick);
    await_run(6, n);
    chk("ring_run", 8'h01, {7'h0, clk_ctrl.cpu_clk_en});
    irq_pending = 1'b0;
    cy(9000);
    rd(`SBC_STAB_STATUS_ADDR, d);
    chk("therm", 8'h18, d);
  endtask : t_stop_ring
  task automatic t_clear;
    logic [7:0] d;
    pulse(xstop_wr);
    rd(`SBC_STAB_STATUS_ADDR, d);
    chk("xstop_clear", 8'h00, d);
    cy(2100);
    rd(`SBC_STAB_STATUS_ADDR, d);
    chk("recount", 8'h10, d);
    pulse(mcc_wr);
    wr(`SBC_STAB_STATUS_ADDR, 8'hff);
    rd(`SBC_STAB_STATUS_ADDR, d);
    chk("mcc_clear", 8'h00, d);
  endtask : t_clear
  task automatic t_misc;
    cpu_src = SBC_SRC_MAIN;
    ring_stop = 1'b1;
    cy(1);
    chk("ring_stop", 8'h00, {7'h0, clk_ctrl.internal_ring_oscillator_en});
    ring_stop = 1'b0;
    cy(1);
    chk("ring_back", 8'h01, {7'h0, clk_ctrl.internal_ring_oscillator_en});
    cpu_src = SBC_SRC_SUB;
    pulse(stop_exec);
    chk("sub_stop", 8'h00, {7'h0, standby});
  endtask : t_misc
  // ****
  // Clock, watchdog and main sequence
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #500000;
    err_total++;
    complete_run();
  end
  initial begin
    {srst, halt_exec, stop_exec, xstop_wr, mcc_wr, irq_pending, ring_tick} = 7'h40;
    started = 1'b1;
    ring_stop = 1'b0;
    sub_used = 1'b1;
    cpu_src = SBC_SRC_MAIN;
    bus = '0;
    cy(4);
    srst = 1'b0;
    cy(1);
    t_reset();
    t_halt();
    t_stop_main();
    t_stop_ring();
    t_clear();
    t_misc();
    complete_run();
  end
endmodule : tb
